// [rtl/serial_flash_instruction_frontend.sv]
`include "sfif_params.svh"
`default_nettype none
module serial_flash_instruction_frontend (
   // system clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // serial link
   input wire logic clk_link_i,
   input wire logic select_n_i,
   input wire logic serial_in_i,
   output logic serial_out_o,
   output logic serial_out_oe_o,
   // array datapath
   input wire logic array_done_i,
   output logic cmd_start_o,
   output sfif_pkg::flash_cmd_t cmd_o,
   // state flags
   output logic busy_o,
   output logic write_latch_o,
   output logic sleep_o,
   output logic otp_mode_o,
   output logic [7:0] status_o
);
   import sfif_pkg::*;

   // link-domain frame state, clocked by the host's clock
   link_state_t l_ff;
   link_state_t nxt_l;
   // system-domain flags and command hand-off
   sys_state_t s_ff;
   sys_state_t nxt_s;
   // output flops and the per-frame reset
   logic armed_ff;
   logic dout_ff;
   logic doe_ff;
   logic frame_rst;

   // link logic restarts for every frame; deselect ends output at once
   assign frame_rst = rst_i | select_n_i;

   // first edge of a frame arms the capture
   always_ff @(posedge clk_link_i or posedge frame_rst) begin
      if (frame_rst) begin
         armed_ff <= 1'b0;
      end else begin
         armed_ff <= 1'b1;
      end
   end

   // link capture: bit and byte counting, address and output staging
   always_comb begin
      logic [2:0] cnt3;
      logic [3:0] nb;
      logic [3:0] nbn;
      logic [3:0] hdr;
      logic [7:0] b;
      logic [7:0] op;
      logic [3:0] idx;
      logic sel;
      logic [7:0] obyte;
      cnt3 = armed_ff ? l_ff.bit3 : 3'h0;
      nb = armed_ff ? l_ff.bytes : `NB_NONE;
      nbn = nb;
      hdr = `NB_NONE;
      b = {l_ff.sh, serial_in_i};
      op = l_ff.opcode;
      idx = 4'h0;
      sel = l_ff.sel0;
      obyte = 8'h00;
      nxt_l = l_ff;
      if (!select_n_i) begin
         // a new frame counts its bytes from zero on its first edge; a frame with no link edge leaves the old count to be evaluated
         nxt_l.bytes = nb;
         // shift one bit in and move the output byte along
         nxt_l.sh = b[6:0];
         nxt_l.bit3 = cnt3 + 3'h1;
         nxt_l.out_sh = {l_ff.out_sh[6:0], 1'b0};
         nxt_l.out_on = armed_ff & l_ff.out_on;
         if (cnt3 == `BIT_LAST) begin
            // byte boundary: count it, saturating at the top
            nbn = (nb == `NB_MAX) ? nb : nb + 4'h1;
            nxt_l.bytes = nbn;
            // the first byte is the opcode
            if (nb == `NB_NONE) begin
               op = b;
               nxt_l.opcode = b;
            end
            // bytes two to four build the address, high byte first
            if (nb >= `NB_OPCODE && nb <= `NB_ADDR_END) begin
               nxt_l.addr = {l_ff.addr[15:0], b};
            end
            // the second byte is kept as status-write data
            if (nb == `NB_OPCODE) begin
               nxt_l.data = b;
            end
            // the fourth byte of 90h picks which code leads
            if (nb == `NB_ADDR_END) begin
               sel = b[0];
               nxt_l.sel0 = b[0];
            end
            // bytes before the first returned byte
            case (op)
               `OP_STAT_RD: hdr = `NB_OPCODE;
               `OP_IDENT: hdr = `NB_OPCODE;
               `OP_WAKE_ID: hdr = `NB_WAKE_MIN;
               `OP_CODES: hdr = `NB_HDR_CODES;
               default: hdr = `NB_NONE;
            endcase
            // position of this byte within the returned data
            idx = nbn - hdr;
            // returned byte for this position
            case (op)
               `OP_STAT_RD: obyte = s_ff.pub;
               `OP_WAKE_ID: obyte = `PART_CODE;
               `OP_CODES: obyte = (idx[0] == sel) ? `MAKER_CODE : `PART_CODE;
               `OP_IDENT: begin
                  case (idx)
                     4'h0: obyte = `MAKER_CODE;
                     4'h1: obyte = `PART_CODE_HI;
                     4'h2: obyte = `PART_CODE;
                     default: obyte = 8'h00;
                  endcase
               end
               default: obyte = 8'h00;
            endcase
            // sleeping device answers only the wake command
            if (hdr != `NB_NONE && nbn >= hdr && !(s_ff.pub_sleep && op != `OP_WAKE_ID)) begin
               nxt_l.out_sh = obyte;
               nxt_l.out_on = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk_link_i or posedge rst_i) begin
      if (rst_i) begin
         l_ff <= '0;
      end else begin
         l_ff <= nxt_l;
      end
   end

   // output bit changes on the falling edge, cut off by deselect
   always_ff @(negedge clk_link_i or posedge frame_rst) begin
      if (frame_rst) begin
         dout_ff <= 1'b0;
         doe_ff <= 1'b0;
      end else begin
         // next bit leaves half a period before the host samples it
         dout_ff <= l_ff.out_sh[7];
         doe_ff <= l_ff.out_on;
      end
   end

   // system side: deselect sync, flag upkeep, frame evaluation
   always_comb begin
      logic whole;
      logic free;
      logic [3:0] nb;
      logic [7:0] op;
      // frame summary is stable: the link clock idles once deselect is seen
      whole = (l_ff.bit3 == 3'h0);
      nb = l_ff.bytes;
      op = l_ff.opcode;
      // write-class work needs the latch and an idle array
      free = s_ff.latch & ~s_ff.busy;
      nxt_s = s_ff;
      // deselect crosses through two flops; a third copy finds its rising edge
      nxt_s.cs_m = select_n_i;
      nxt_s.cs_s = s_ff.cs_m;
      nxt_s.cs_d = s_ff.cs_s;
      nxt_s.start = 1'b0;
      // snapshot for the link, frozen while a frame is open
      if (s_ff.cs_s && s_ff.cs_d) begin
         nxt_s.pub = 8'h00;
         nxt_s.pub[`ST_BUSY] = s_ff.busy;
         nxt_s.pub[`ST_LATCH] = s_ff.latch;
         nxt_s.pub[`ST_BP_HI:`ST_BP_LO] = s_ff.bp;
         nxt_s.pub[`ST_SRP] = s_ff.srp;
         nxt_s.pub_sleep = s_ff.sleep;
      end
      // cycle completion
      if (array_done_i && s_ff.busy) begin
         nxt_s.busy = 1'b0;
         nxt_s.latch = 1'b0;
      end
      // evaluate the finished frame on deselect
      if (s_ff.cs_s && !s_ff.cs_d && nb != `NB_NONE) begin
         // a sleeping device answers only the wake command
         if (s_ff.sleep) begin
            if (op == `OP_WAKE_ID && nb >= `NB_WAKE_MIN) begin
               nxt_s.sleep = 1'b0;
            end
         end else begin
            case (op)
               // 06h: latch set, applied after any completion clear
               `OP_SET_LATCH: begin
                  if (whole && nb == `NB_OPCODE) begin
                     nxt_s.latch = 1'b1;
                  end
               end
               // 04h: leaves one-time mode first, else drops the latch
               `OP_CLR_LATCH: begin
                  if (whole && nb == `NB_OPCODE) begin
                     if (s_ff.otp) begin
                        nxt_s.otp = 1'b0;
                     end else begin
                        nxt_s.latch = 1'b0;
                     end
                  end
               end
               // 01h: opcode plus exactly one data byte
               `OP_STAT_WR: begin
                  if (whole && nb == `NB_STAT_WR && free) begin
                     nxt_s.busy = 1'b1;
                     nxt_s.start = 1'b1;
                     nxt_s.cmd.kind = cmd_status_write;
                     nxt_s.cmd.data = l_ff.data;
                     if (s_ff.otp) begin
                        nxt_s.srp = 1'b1;
                     end else begin
                        nxt_s.srp = l_ff.data[`ST_SRP];
                        nxt_s.bp = l_ff.data[`ST_BP_HI:`ST_BP_LO];
                     end
                  end
               end
               // 02h: address plus at least one data byte
               `OP_PAGE_WR: begin
                  // partial byte leaves everything, latch included
                  if (whole && nb >= `NB_PAGE_MIN && free) begin
                     nxt_s.busy = 1'b1;
                     nxt_s.start = 1'b1;
                     nxt_s.cmd.kind = cmd_page_write;
                     nxt_s.cmd.addr = l_ff.addr;
                  end
               end
               // 20h: exactly a three-byte address
               `OP_SECT_ER: begin
                  if (whole && nb == `NB_ERASE && free) begin
                     nxt_s.busy = 1'b1;
                     nxt_s.start = 1'b1;
                     nxt_s.cmd.kind = cmd_sector_erase;
                     nxt_s.cmd.addr = l_ff.addr;
                  end
               end
               // d8h or 52h: exactly a three-byte address
               `OP_BLK_ER_A, `OP_BLK_ER_B: begin
                  if (whole && nb == `NB_ERASE && free) begin
                     nxt_s.busy = 1'b1;
                     nxt_s.start = 1'b1;
                     nxt_s.cmd.kind = cmd_block_erase;
                     nxt_s.cmd.addr = l_ff.addr;
                  end
               end
               // c7h or 60h: opcode only
               `OP_FULL_ER_A, `OP_FULL_ER_B: begin
                  if (whole && nb == `NB_OPCODE && free) begin
                     nxt_s.busy = 1'b1;
                     nxt_s.start = 1'b1;
                     nxt_s.cmd.kind = cmd_full_erase;
                  end
               end
               // b9h: refused while a cycle runs, so no work is stranded
               `OP_SLEEP: begin
                  if (whole && nb == `NB_OPCODE && !s_ff.busy) begin
                     nxt_s.sleep = 1'b1;
                  end
               end
               // 3ah: one-time mode, allowed while busy
               `OP_OTP: begin
                  if (whole && nb == `NB_OPCODE) begin
                     nxt_s.otp = 1'b1;
                  end
               end
               // 03h and 0bh: address handed on, data streaming lies outside
               `OP_READ, `OP_QUICK: begin
                  // a read reaching its address is passed on unless busy
                  if (nb >= `NB_ERASE && !s_ff.busy) begin
                     nxt_s.start = 1'b1;
                     nxt_s.cmd.kind = (op == `OP_QUICK) ? cmd_quick_read : cmd_read;
                     nxt_s.cmd.addr = l_ff.addr;
                  end
               end
               // unknown opcodes leave every flag alone
               default: begin
                  nxt_s.start = 1'b0;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         s_ff <= '0;
         // sync flops reset to the deselected level so no false edge follows
         s_ff.cs_m <= 1'b1;
         s_ff.cs_s <= 1'b1;
         s_ff.cs_d <= 1'b1;
         s_ff.pub <= `ST_RESET;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // outputs, all from flip-flops
   assign serial_out_o = dout_ff;
   assign serial_out_oe_o = doe_ff;
   assign cmd_start_o = s_ff.start;
   assign cmd_o = s_ff.cmd;
   assign busy_o = s_ff.busy;
   assign write_latch_o = s_ff.latch;
   assign sleep_o = s_ff.sleep;
   assign otp_mode_o = s_ff.otp;
   assign status_o = s_ff.pub;

endmodule
`default_nettype wire

// [rtl/sfif_params.svh]
`ifndef SFIF_PARAMS_SVH
`define SFIF_PARAMS_SVH

// opcodes
`define OP_SET_LATCH 8'h06
`define OP_CLR_LATCH 8'h04
`define OP_STAT_RD 8'h05
`define OP_STAT_WR 8'h01
`define OP_READ 8'h03
`define OP_QUICK 8'h0b
`define OP_PAGE_WR 8'h02
`define OP_SECT_ER 8'h20
`define OP_BLK_ER_A 8'hd8
`define OP_BLK_ER_B 8'h52
`define OP_FULL_ER_A 8'hc7
`define OP_FULL_ER_B 8'h60
`define OP_SLEEP 8'hb9
`define OP_WAKE_ID 8'hab
`define OP_CODES 8'h90
`define OP_IDENT 8'h9f
`define OP_OTP 8'h3a

// byte counts of a frame, opcode included, and the index of the last bit in a byte
`define NB_NONE 4'h0
`define NB_OPCODE 4'h1
`define NB_STAT_WR 4'h2
`define NB_ADDR_END 4'h3
`define NB_ERASE 4'h4
`define NB_PAGE_MIN 4'h5
`define NB_WAKE_MIN 4'h4
`define NB_HDR_CODES 4'h4
`define NB_MAX 4'hf
`define BIT_LAST 3'h7

// status byte layout and reset value
`define ST_BUSY 0
`define ST_LATCH 1
`define ST_BP_LO 2
`define ST_BP_HI 4
`define ST_SRP 7
`define ST_RESET 8'h00

// identity codes, values arbitrary
`define MAKER_CODE 8'h5a
`define PART_CODE 8'h3c
`define PART_CODE_HI 8'h7e

`endif

// [rtl/sfif_pkg.sv]
`default_nettype none
package sfif_pkg;

   // write-class and read work handed to the array datapath
   typedef enum logic [2:0] {
      cmd_none,
      cmd_status_write,
      cmd_page_write,
      cmd_sector_erase,
      cmd_block_erase,
      cmd_full_erase,
      cmd_read,
      cmd_quick_read
   } cmd_kind_t;

   typedef struct packed {
      cmd_kind_t kind;
      logic [23:0] addr;
      logic [7:0] data;
   } flash_cmd_t;

   // link-side frame capture
   typedef struct packed {
      logic [2:0] bit3;
      logic [3:0] bytes;
      logic [6:0] sh;
      logic [7:0] opcode;
      logic [23:0] addr;
      logic [7:0] data;
      logic sel0;
      logic out_on;
      logic [7:0] out_sh;
   } link_state_t;

   // system-side flags and command evaluation
   typedef struct packed {
      logic cs_m;
      logic cs_s;
      logic cs_d;
      logic busy;
      logic latch;
      logic sleep;
      logic otp;
      logic srp;
      logic [2:0] bp;
      logic start;
      flash_cmd_t cmd;
      logic [7:0] pub;
      logic pub_sleep;
   } sys_state_t;

endpackage
`default_nettype wire

// [testbench/serial_flash_instruction_frontend_tb_top.sv]
`include "sfif_params.svh"
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module serial_flash_instruction_frontend_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import sfif_pkg::*;
   logic clk = 1'b0, rst = 1'b1, done = 1'b0;
   logic clk_link, select_n, serial_in, serial_out, out_oe, start, busy, latch, sleep, otp;
   logic [7:0] status;
   logic [31:0] rx;
   flash_cmd_t cmd, last;
   int failures = 0, checked = 0, starts = 0, oe_hits = 0;
   always #20 clk = ~clk;
   // record every command handed to the datapath
   always @(posedge clk) if (start) begin
      starts++;
      last = cmd;
   end
   always @(posedge out_oe) oe_hits++;
   serial_flash_instruction_frontend dut (.clk_sys_i(clk), .rst_i(rst), .clk_link_i(clk_link),
      .select_n_i(select_n), .serial_in_i(serial_in), .serial_out_o(serial_out), .serial_out_oe_o(out_oe),
      .array_done_i(done), .cmd_start_o(start), .cmd_o(cmd), .busy_o(busy), .write_latch_o(latch),
      .sleep_o(sleep), .otp_mode_o(otp), .status_o(status));
   sfif_host host (.clk_link_o(clk_link), .select_n_o(select_n), .serial_in_o(serial_in), .serial_out_i(serial_out));
   task automatic xfer(input logic [71:0] bits, input int n);
      host.frame(bits, n, rx);
   endtask
   task automatic finish_cycle;
      @(posedge clk) done <= 1'b1;
      @(posedge clk) done <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   task automatic wrap_up;
      $display("checked=%0d failures=%0d", checked, failures);
      if (failures == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic t_flags;
      int n0;
      xfer({8'h03, 64'h0}, 32);
      n0 = starts;
      xfer({8'h06, 64'h0}, 5);
      `CHK(latch, 1'b0)
      `CHK(starts, n0)
      xfer({8'h06, 64'h0}, 9);
      `CHK(latch, 1'b0)
      xfer({8'h06, 64'h0}, 8);
      `CHK(latch, 1'b1)
      xfer({8'h04, 64'h0}, 8);
      `CHK(latch, 1'b0)
      xfer({8'h3a, 64'h0}, 8);
      `CHK(otp, 1'b1)
      xfer({8'h04, 64'h0}, 8);
      `CHK(otp, 1'b0)
      $display("t_flags done");
   endtask
   task automatic t_cmds;
      logic [7:0] op [15] = '{8'h01, 8'h02, 8'h20, 8'hd8, 8'h52, 8'hc7, 8'h60, 8'h03, 8'h0b,
         8'h20, 8'h02, 8'h02, 8'hc7, 8'h01, 8'h20};
      int nb [15] = '{16, 40, 32, 32, 32, 8, 8, 32, 40, 40, 32, 43, 9, 24, 24};
      cmd_kind_t k [15] = '{cmd_status_write, cmd_page_write, cmd_sector_erase, cmd_block_erase, cmd_block_erase,
         cmd_full_erase, cmd_full_erase, cmd_read, cmd_quick_read, cmd_none, cmd_none, cmd_none, cmd_none,
         cmd_none, cmd_none};
      int n0;
      logic wr;
      for (int i = 0; i < 15; i++) begin
         xfer({8'h06, 64'h0}, 8);
         n0 = starts;
         xfer({op[i], 24'h603456, 8'hc3, 32'h0}, nb[i]);
         `CHK(starts, n0 + (k[i] != cmd_none))
         wr = k[i] inside {cmd_status_write, cmd_page_write, cmd_sector_erase, cmd_block_erase, cmd_full_erase};
         if (k[i] == cmd_none) begin
            `CHK(latch, 1'b1)
            xfer({8'h04, 64'h0}, 8);
         end else begin
            `CHK(last.kind, k[i])
            `CHK(busy, wr)
            if (k[i] == cmd_status_write) `CHK(last.data, 8'h60)
            else if (k[i] != cmd_full_erase) `CHK(last.addr, 24'h603456)
            if (wr) begin
               xfer({8'h05, 64'h0}, 24);
               `CHK(rx[15:0], 16'h0303)
               `CHK(status, 8'h03)
               n0 = starts;
               xfer({8'h03, 64'h0}, 32);
               `CHK(starts, n0)
               finish_cycle();
               `CHK({busy, latch, status}, 10'h000)
            end
         end
      end
      $display("t_cmds done");
   endtask
   task automatic t_ident;
      xfer({8'h9f, 64'h0}, 32);
      `CHK(rx[23:0], {`MAKER_CODE, `PART_CODE_HI, `PART_CODE})
      xfer({8'h9f, 64'h0}, 13);
      `CHK(rx[4:0], `MAKER_CODE >> 3)
      `CHK(out_oe, 1'b0)
      xfer({8'h90, 24'h000000, 40'h0}, 48);
      `CHK(rx[15:0], {`MAKER_CODE, `PART_CODE})
      xfer({8'h90, 24'h000001, 40'h0}, 48);
      `CHK(rx[15:0], {`PART_CODE, `MAKER_CODE})
      xfer({8'hab, 64'h0}, 48);
      `CHK(rx[15:0], {`PART_CODE, `PART_CODE})
      $display("t_ident done");
   endtask
   task automatic t_sleep;
      int n0;
      xfer({8'hb9, 64'h0}, 8);
      `CHK(sleep, 1'b1)
      n0 = oe_hits;
      xfer({8'h05, 64'h0}, 16);
      `CHK(oe_hits, n0)
      xfer({8'hab, 64'h0}, 16);
      `CHK(sleep, 1'b1)
      xfer({8'hab, 64'h0}, 40);
      `CHK({sleep, rx[7:0]}, {1'b0, `PART_CODE})
      $display("t_sleep done");
   endtask
   // main sequence
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      `CHK({busy, latch, sleep, otp, start}, 5'h00)
      t_flags();
      t_cmds();
      t_ident();
      t_sleep();
      wrap_up();
   end
   // hang guard
   initial begin
      #1000000;
      failures++;
      wrap_up();
   end
endmodule
`default_nettype wire

// [testbench/sfif_chk.sv]
`default_nettype none
module sfif_chk import sfif_pkg::*; (
   // clocks and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic clk_link_i,
   // link
   input wire logic select_n_i,
   input wire logic serial_in_i,
   input wire logic serial_out_o,
   input wire logic serial_out_oe_o,
   // datapath and flags
   input wire logic array_done_i,
   input wire logic cmd_start_o,
   input wire sfif_pkg::flash_cmd_t cmd_o,
   input wire logic busy_o,
   input wire logic write_latch_o,
   input wire logic sleep_o,
   input wire logic otp_mode_o,
   input wire logic [7:0] status_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [6:0] nbit_ff;
   logic wr_kind;
   // rising link edges since select fell
   always_ff @(posedge clk_link_i or posedge select_n_i) begin
      if (select_n_i) nbit_ff <= 7'h00;
      else nbit_ff <= nbit_ff + 7'h01;
   end
   // write-class command on the datapath port
   assign wr_kind = cmd_o.kind inside {cmd_status_write, cmd_page_write, cmd_sector_erase, cmd_block_erase,
      cmd_full_erase};
   sequence s_finish;
      array_done_i && busy_o;
   endsequence
   a_latch_first: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      cmd_start_o && wr_kind |-> $past(write_latch_o)) else $error("write command without latch");
   a_busy_blocks: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      cmd_start_o |-> !$past(busy_o)) else $error("command started while busy");
   a_start_busy: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      cmd_start_o && wr_kind |-> busy_o) else $error("busy not set by write command");
   a_busy_cause: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      $rose(busy_o) |-> cmd_start_o && wr_kind) else $error("busy rose without command");
   a_done_clears: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      s_finish |=> !busy_o && !write_latch_o) else $error("completion left busy or latch");
   a_start_pulse: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      cmd_start_o |=> !cmd_start_o) else $error("start longer than one cycle");
   a_oe_desel: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      select_n_i |-> !serial_out_oe_o) else $error("output driven while deselected");
   a_out_after_op: assert property (@(posedge clk_link_i) disable iff (rst_i || select_n_i)
      serial_out_oe_o |-> nbit_ff >= 7'h08) else $error("output before opcode complete");
endmodule
bind serial_flash_instruction_frontend sfif_chk u_chk (.clk_sys_i, .rst_i, .clk_link_i, .select_n_i,
   .serial_in_i, .serial_out_o, .serial_out_oe_o, .array_done_i, .cmd_start_o, .cmd_o, .busy_o,
   .write_latch_o, .sleep_o, .otp_mode_o, .status_o);
`default_nettype wire

// [testbench/sfif_host.sv]
`default_nettype none
module sfif_host (
   // serial link
   output logic clk_link_o,
   output logic select_n_o,
   output logic serial_in_o,
   input wire logic serial_out_i
);
   timeunit 1ns;
   timeprecision 1ps;
   // idle: clock low, deselected
   initial begin
      clk_link_o = 1'b0;
      select_n_o = 1'b1;
      serial_in_o = 1'b0;
   end
   // one frame of n bits, opcode first; returns the last 32 bits seen on the output
   task automatic frame(input logic [71:0] bits, input int n, output logic [31:0] rx);
      rx = 32'h0;
      select_n_o = 1'b0;
      for (int i = 0; i < n; i++) begin
         serial_in_o = bits[71 - i];
         #32 clk_link_o = 1'b1;
         rx = {rx[30:0], serial_out_i};
         #32 clk_link_o = 1'b0;
      end
      select_n_o = 1'b1;
      serial_in_o = ~serial_in_o;
      #200;
   endtask
endmodule
`default_nettype wire
